// ==== hw/crs_sequencer.sv ====
// reset stretcher, strap capture, shutdown handling and reset control reg
// assumes all inputs synchronous to clock except reset_input_n
`timescale 1ns/1ns
`include "crs_map.svh"
module crs_sequencer
    import crs_pkg::*;
#(
    parameter int unsigned EXT_CYCLES = `CRS_EXT_CYCLES
)(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // reset from the bridge and outputs to processor side
    input  wire logic         reset_input_n,
    output logic              processor_reset_out_n,
    output logic              companion_reset_out_n,
    // strap pins
    input  wire logic         ecc_error_strap_pin_n,
    input  wire logic         ecc_check_bit_zero,
    input  wire logic         mem_clock_enable_pin,
    output crs_strap_t        strap,
    // host bus shutdown detection and completion
    input  wire logic         shutdown_cycle,
    output logic              host_target_ready_n,
    output logic [2:0]        host_response,
    // configuration register port
    input  wire crs_cfg_req_t cfg_req,
    output logic [7:0]        cfg_rdata,
    // soft-init and self-test status
    output logic              soft_init_out_n,
    output logic              in_order_queue,
    output logic              non_operational
);
    logic        rst_meta;
    logic        rst_sync;
    logic        rst_sync_d;
    logic [17:0] ext_count;
    logic [17:0] next_ext_count;
    logic [1:0]  tail_count;
    logic [1:0]  next_tail_count;
    crs_state_t  state;
    crs_state_t  next_state;
    logic        next_cpu_n;
    logic        next_comp_n;
    crs_strap_t  next_strap;
    logic [7:0]  ctrl;
    logic [7:0]  next_ctrl;
    logic [7:0]  next_rdata;
    logic        next_tready_n;
    logic        next_selftest;
    logic        shut_done;
    logic        next_shut_done;
    logic        reg_hit;
    logic        qualified;
    logic        init_trigger;

    function automatic logic reg_write(input crs_cfg_req_t r);
        return r.write && (r.addr == `CRS_REG_OFFSET);
    endfunction

    // two-flop synchroniser on the reset input
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rst_meta   <= 1'b0;
            rst_sync   <= 1'b0;
            rst_sync_d <= 1'b0;
        end else begin
            rst_meta   <= reset_input_n;
            rst_sync   <= rst_meta;
            rst_sync_d <= rst_sync;
        end
    end

    // stretch state: hold while input low, count 1 ms, then tail
    always_comb begin
        next_state      = state;
        next_ext_count  = ext_count;
        next_tail_count = tail_count;
        next_cpu_n      = 1'b0;
        next_comp_n     = 1'b0;
        if (!rst_sync) begin
            next_state     = CRS_HOLD;
            next_ext_count = 18'h0;
        end else begin
            case (state)
                CRS_HOLD: begin
                    // a bridge-driven hard reset re-enters here
                    if (ext_count == 18'(EXT_CYCLES - 1)) begin
                        next_state      = CRS_CPU_OUT;
                        next_tail_count = 2'h0;
                        next_cpu_n      = 1'b1;
                    end else begin
                        next_ext_count = ext_count + 18'h1;
                    end
                end
                CRS_CPU_OUT: begin
                    next_cpu_n = 1'b1;
                    if (tail_count == 2'(`CRS_COMPANION_RESET_OUT_N_EXTRA - 1)) begin
                        next_state  = CRS_RUN;
                        next_comp_n = 1'b1;
                    end else begin
                        next_tail_count = tail_count + 2'h1;
                    end
                end
                CRS_RUN: begin
                    next_cpu_n  = 1'b1;
                    next_comp_n = 1'b1;
                end
                default: begin
                    next_state = CRS_HOLD;
                end
            endcase
        end
    end

    // registered outputs keep reset assertion on a clock edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state                 <= CRS_HOLD;
            ext_count             <= 18'h0;
            tail_count            <= 2'h0;
            processor_reset_out_n <= 1'b0;
            companion_reset_out_n <= 1'b0;
        end else begin
            state                 <= next_state;
            ext_count             <= next_ext_count;
            tail_count            <= next_tail_count;
            processor_reset_out_n <= next_cpu_n;
            companion_reset_out_n <= next_comp_n;
        end
    end

    // straps caught when the synchronised input first goes high
    always_comb begin
        next_strap = strap;
        if (rst_sync && !rst_sync_d) begin
            next_strap.ecc_error_strap    = ~ecc_error_strap_pin_n;
            next_strap.ecc_check_bit_zero = ecc_check_bit_zero;
            next_strap.mem_clock_enable   = mem_clock_enable_pin;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            strap <= '0;
        end else begin
            strap <= next_strap;
        end
    end

    // reset control register and shutdown completion
    assign reg_hit   = reg_write(cfg_req);
    assign qualified = reg_hit
                    && !cfg_req.wdata[`CRS_BIT_SELFTEST]
                    && cfg_req.wdata[`CRS_BIT_ENABLE]
                    && cfg_req.wdata[`CRS_BIT_TRIGGER]
                    && !ctrl[`CRS_BIT_TRIGGER]
                    && rst_sync; // writes refused while reset input low
    assign init_trigger = qualified || shut_done;

    always_comb begin
        next_ctrl      = ctrl;
        next_tready_n  = 1'b1;
        next_shut_done = 1'b0;
        if (reg_hit) begin
            next_ctrl = cfg_req.wdata;
        end
        if (shutdown_cycle && host_target_ready_n) begin
            next_tready_n  = 1'b0;
            next_shut_done = 1'b1;
        end
        next_selftest = next_ctrl[`CRS_BIT_SELFTEST];
        next_rdata    = (cfg_req.addr == `CRS_REG_OFFSET) ? next_ctrl : 8'h00;
    end

    // low synchronised reset input clears the register so self-test ends on hard reset
    always_ff @(posedge clock) begin
        if (sys_rst || !rst_sync) begin
            ctrl                <= `CRS_REG_RESET;
            cfg_rdata           <= 8'h00;
            host_target_ready_n <= 1'b1;
            host_response       <= `CRS_RESP_NODATA;
            shut_done           <= 1'b0;
            in_order_queue      <= `CRS_IOQ_FULL;
            non_operational     <= 1'b0;
        end else begin
            ctrl                <= next_ctrl;
            cfg_rdata           <= next_rdata;
            host_target_ready_n <= next_tready_n;
            host_response       <= `CRS_RESP_NODATA;
            shut_done           <= next_shut_done;
            in_order_queue      <= next_selftest ? `CRS_IOQ_ONE
                                                 : `CRS_IOQ_FULL;
            non_operational     <= next_selftest;
        end
    end

    // pulse width is fixed inside the stretcher
    crs_init_pulse u_init (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .trigger    (init_trigger),
        .init_out_n (soft_init_out_n)
    );
endmodule

// ==== pkg/crs_map.svh ====
// reset/init sequencer constants: offsets, bit positions, timing counts
// assumes a 250 MHz host clock and an 8-bit config register port
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
`define CRS_CLK_MHZ        250
`define CRS_EXT_TIME_US    1000
`define CRS_EXT_CYCLES     (`CRS_EXT_TIME_US * `CRS_CLK_MHZ)
`define CRS_COMPANION_RESET_OUT_N_EXTRA   2
`define CRS_INIT_CLKS      4
`define CRS_REG_OFFSET     8'h93
`define CRS_REG_RESET      8'h00
`define CRS_BIT_SELFTEST   3
`define CRS_BIT_TRIGGER    2
`define CRS_BIT_ENABLE     1
`define CRS_RESP_NODATA    3'h0
`define CRS_IOQ_FULL       1'b0
`define CRS_IOQ_ONE        1'b1
`endif

// ==== pkg/crs_pkg.sv ====
// types for the reset and soft-init sequencer
// assumes crs_map.svh provides the numeric constants
package crs_pkg;
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crs_cfg_req_t;
    typedef struct packed {
        logic ecc_error_strap;
        logic ecc_check_bit_zero;
        logic mem_clock_enable;
    } crs_strap_t;
    typedef enum logic [1:0] {
        CRS_HOLD,
        CRS_CPU_OUT,
        CRS_RUN
    } crs_state_t;
endpackage

// ==== hw/crs_init_pulse.sv ====
// soft-init pulse stretcher: one trigger gives a fixed low pulse
// assumes trigger is a one-cycle request from the sequencer
`timescale 1ns/1ns
`include "crs_map.svh"
module crs_init_pulse
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // request and pin
    input  wire logic trigger,
    output logic      init_out_n
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic       next_init_out_n;

    // retrigger restarts the full width, so pulses never shorten
    always_comb begin
        next_count      = count;
        next_init_out_n = 1'b1;
        if (trigger) begin
            next_count = 3'(`CRS_INIT_CLKS);
        end else if (count != 3'h0) begin
            next_count = count - 3'h1;
        end
        if (next_count != 3'h0) begin
            next_init_out_n = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count      <= 3'h0;
            init_out_n <= 1'b1;
        end else begin
            count      <= next_count;
            init_out_n <= next_init_out_n;
        end
    end
endmodule

// ==== tb/crs_sequencer_props.sv ====
// pin-level assertions for the reset and soft-init sequencer
// assumes one host clock domain and the synchronous sys_rst
`timescale 1ns/1ns
`include "crs_map.svh"
module crs_sequencer_props
    import crs_pkg::*;
#(
    parameter int unsigned EXT_CYCLES = 20
)(
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // reset path
    input wire logic       reset_input_n,
    input wire logic       processor_reset_out_n,
    input wire logic       companion_reset_out_n,
    input wire crs_strap_t strap,
    // shutdown, soft-init and self-test
    input wire logic       host_target_ready_n,
    input wire logic [2:0] host_response,
    input wire logic       soft_init_out_n,
    input wire logic       in_order_queue,
    input wire logic       non_operational
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    int unsigned hi_cnt;
    // cycles since reset input last seen low; saturates to stay cheap
    always_ff @(posedge clock) begin
        if (sys_rst || !reset_input_n) hi_cnt <= 0;
        else if (hi_cnt < EXT_CYCLES + 8) hi_cnt <= hi_cnt + 1;
    end
    sequence init_low4;
        !soft_init_out_n [*4];
    endsequence
    sequence tready_once;
        !host_target_ready_n ##1 host_target_ready_n;
    endsequence
    // zero count excluded: the input synchroniser delays the assertion
    a_ext_hold: assert property (
        hi_cnt != 0 && hi_cnt < EXT_CYCLES |-> !processor_reset_out_n)
        else $error("processor reset released early");
    a_ext_time: assert property (
        $rose(processor_reset_out_n)
        |-> hi_cnt >= EXT_CYCLES && hi_cnt <= EXT_CYCLES + 4)
        else $error("processor reset release time off");
    a_reset_assert: assert property (
        $fell(reset_input_n)
        |-> ##[1:4] (!processor_reset_out_n && !companion_reset_out_n))
        else $error("resets not asserted");
    a_comp_lag: assert property (
        $rose(processor_reset_out_n) |-> ##2 $rose(companion_reset_out_n))
        else $error("companion release not two clocks later");
    a_comp_order: assert property (
        !processor_reset_out_n |-> !companion_reset_out_n)
        else $error("companion released before processor");
    a_strap_hold: assert property (hi_cnt > 6 |-> $stable(strap))
        else $error("straps changed after capture");
    a_nodata_resp: assert property (
        !host_target_ready_n |-> host_response == `CRS_RESP_NODATA)
        else $error("shutdown response not no-data");
    a_tready_pulse: assert property (
        $fell(host_target_ready_n) |-> tready_once)
        else $error("target ready not one cycle");
    a_shutdown_init: assert property (
        $fell(host_target_ready_n) |-> ##[1:3] !soft_init_out_n)
        else $error("no soft-init after shutdown");
    a_init_width: assert property (
        $fell(soft_init_out_n) |-> init_low4)
        else $error("soft-init pulse too short");
    a_selftest_ioq: assert property (
        non_operational |-> in_order_queue == `CRS_IOQ_ONE)
        else $error("self-test without queue depth one");
    cover property ($fell(soft_init_out_n));
endmodule
bind crs_sequencer crs_sequencer_props #(.EXT_CYCLES(EXT_CYCLES)) u_props (
    .clock, .sys_rst, .reset_input_n, .processor_reset_out_n,
    .companion_reset_out_n, .strap, .host_target_ready_n, .host_response,
    .soft_init_out_n, .in_order_queue, .non_operational);

// ==== tb/crs_bridge_model.sv ====
// bus reset source on the bridge side: low at power-up and after requests
// assumes the host clock never stops, so the count always runs
`timescale 1ns/1ns
module crs_bridge_model #(
    parameter int HOLD = 30
)(
    // clock and hard reset request
    input  wire logic clock,
    input  wire logic hard_req,
    // bus reset to the sequencer
    output logic      reset_input_n
);
    int cnt = HOLD;
    // low-time counter, restarted by each request
    always_ff @(posedge clock) begin
        if (hard_req) cnt <= HOLD;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign reset_input_n = (cnt == 0);
endmodule

// ==== tb/crs_sequencer_test.sv ====
// self-checking bench: reset stretch, straps, register writes, shutdown
// assumes the bridge model drives the bus reset; 20-cycle stretch
`timescale 1ns/1ns
`include "crs_map.svh"
module crs_sequencer_test
    import crs_pkg::*;
;
    localparam int EXT = 20;
    logic clock = 0, sys_rst = 1, hard_req = 0, shutdown_cycle = 0;
    logic ecc_error_strap_pin_n = 0, ecc_check_bit_zero = 1;
    logic mem_clock_enable_pin = 0;
    crs_cfg_req_t cfg_req = '0;
    wire reset_input_n, processor_reset_out_n, companion_reset_out_n;
    wire host_target_ready_n, soft_init_out_n, in_order_queue;
    wire non_operational;
    wire crs_strap_t strap;
    wire [2:0] host_response;
    wire [7:0] cfg_rdata;
    int err_count = 0, num_checks = 0, lows, seen;
    // rows: addr, write data, read back, pulse expected
    logic [24:0] rows [10] = '{
        {16'h9302, 8'h02, 1'b0}, {16'h9306, 8'h06, 1'b1},
        {16'h9306, 8'h06, 1'b0}, {16'h92ff, 8'h06, 1'b0},
        {16'h9300, 8'h00, 1'b0}, {16'h9304, 8'h04, 1'b0},
        {16'h9300, 8'h00, 1'b0}, {16'h930e, 8'h0e, 1'b0},
        {16'h9302, 8'h02, 1'b0}, {16'h9306, 8'h06, 1'b1}};
    crs_sequencer #(.EXT_CYCLES(EXT)) dut (.clock, .sys_rst,
        .reset_input_n, .processor_reset_out_n, .companion_reset_out_n,
        .ecc_error_strap_pin_n, .ecc_check_bit_zero, .mem_clock_enable_pin,
        .strap, .shutdown_cycle, .host_target_ready_n, .host_response,
        .cfg_req, .cfg_rdata, .soft_init_out_n, .in_order_queue,
        .non_operational);
    crs_bridge_model #(.HOLD(30)) bridge (.clock, .hard_req, .reset_input_n);
    // 250 MHz host clock
    initial begin
        forever #2 clock = ~clock;
    end
    task check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // wait for bus reset release, then time both output releases
    task release_check;
        int n, pn, cn;
        crs_strap_t want;
        n = 0;
        pn = -1;
        cn = -1;
        while (reset_input_n !== 1'b1 && n < 200) begin
            @(posedge clock);
            n++;
        end
        for (n = 0; n < EXT + 10; n++) begin
            @(posedge clock);
            if (pn < 0 && processor_reset_out_n === 1'b1) pn = n;
            if (cn < 0 && companion_reset_out_n === 1'b1) cn = n;
        end
        // strap pin levels are stable across the release window
        want = {~ecc_error_strap_pin_n, ecc_check_bit_zero,
                mem_clock_enable_pin};
        check(8'(pn >= EXT && pn <= EXT + 4), 8'h01);
        check(8'(cn - pn), 8'(`CRS_COMPANION_RESET_OUT_N_EXTRA));
        check(8'(strap), 8'(want));
    endtask
    // one write, then read back and count soft-init low cycles
    task run_row(input logic [24:0] r);
        logic want_ioq;
        want_ioq = r[4] ? `CRS_IOQ_ONE : `CRS_IOQ_FULL;
        cfg_req <= '{1'b1, r[24:17], r[16:9]};
        @(posedge clock);
        cfg_req <= '{1'b0, `CRS_REG_OFFSET, 8'h00};
        lows = 0;
        repeat (10) begin
            @(posedge clock);
            if (soft_init_out_n === 1'b0) lows++;
        end
        check(cfg_rdata, r[8:1]);
        check(8'(lows), r[0] ? 8'(`CRS_INIT_CLKS) : 8'h00);
        check(8'(non_operational), 8'(r[4]));
        check(8'(in_order_queue), 8'(want_ioq));
    endtask
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        release_check;
        foreach (rows[i]) run_row(rows[i]);
        ecc_error_strap_pin_n <= 1'b1;
        ecc_check_bit_zero <= 1'b0;
        mem_clock_enable_pin <= 1'b1;
        shutdown_cycle <= 1'b1;
        @(posedge clock);
        shutdown_cycle <= 1'b0;
        lows = 0;
        seen = 0;
        repeat (12) begin
            @(posedge clock);
            if (host_target_ready_n === 1'b0) seen++;
            if (soft_init_out_n === 1'b0) lows++;
        end
        check(8'(seen), 8'h01);
        check(8'(host_response), 8'(`CRS_RESP_NODATA));
        check(8'(lows), 8'(`CRS_INIT_CLKS));
        check(8'(strap), 8'h06);
        hard_req <= 1'b1;
        @(posedge clock);
        hard_req <= 1'b0;
        repeat (6) @(posedge clock);
        check(8'({processor_reset_out_n, companion_reset_out_n}), 8'h00);
        check(cfg_rdata, `CRS_REG_RESET);
        // a qualifying write while the bus reset is low must be ignored
        run_row({16'h9306, 8'h00, 1'b0});
        release_check;
        results;
    end
    // hang guard, well past the few hundred cycles the run needs
    initial begin
        repeat (3000) @(posedge clock);
        err_count++;
        results;
    end
endmodule
